// ### adr_pkg.sv
/*
  Shared constants and types of the decimation and output-rate block:
  register offsets, field positions, reset values, rate tables and the
  result carrier. Assumes a 40 MHz APB clock and a 4.608 MHz system rate.
*/
`default_nettype none

package adr_pkg;

	// ------------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------------
	localparam int unsigned PCLK_KHZ    = 40000;
	localparam int unsigned SYS_CLK_KHZ = 4608;
	localparam logic [15:0] PH_WRAP     = 16'(PCLK_KHZ);
	localparam logic [15:0] PH_STEP     = 16'(SYS_CLK_KHZ);

	// ------------------------------------------------------------------
	// Register offsets and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_SETUP1 = 8'h00;
	localparam logic [7:0] OFS_SETUP2 = 8'h04;
	localparam logic [7:0] OFS_WAIT   = 8'h08;
	localparam logic [7:0] OFS_SYS    = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;

	localparam int RATE_LSB    = 0;
	localparam int ORDER_LSB   = 8;
	localparam int NORMAL_BIT  = 0;
	localparam int SHORT_BIT   = 0;
	localparam int RUN_BIT     = 1;
	localparam int OVR_BIT     = 0;
	localparam int SETTLED_BIT = 1;
	localparam int LEVEL_LSB   = 2;
	localparam int STATE_LSB   = 4;
	localparam int RES_SET_BIT = 24;

	localparam logic [4:0] RATE_RST   = 5'h00;
	localparam logic [2:0] ORDER_RST  = 3'h0;
	localparam logic       NORMAL_RST = 1'b1;
	localparam logic [5:0] WAIT_RST   = 6'h00;
	localparam logic       SHORT_RST  = 1'b0;
	localparam logic       RUN_RST    = 1'b0;

	// ------------------------------------------------------------------
	// Filter figures
	// ------------------------------------------------------------------
	localparam logic [4:0]  MAX_CODE    = 5'h1c;
	localparam logic [4:0]  BYPASS_LAST = 5'h0b;
	localparam logic [2:0]  S1_ORDER    = 3'h4;
	localparam logic [2:0]  S2_MAX_ORD  = 3'h4;
	localparam logic [11:0] WAIT_UNIT   = 12'h040;
	localparam logic [23:0] MOD_POS     = 24'h400000;
	localparam logic [23:0] MOD_NEG     = 24'hc00000;
	localparam int          S1_W        = 60;
	localparam int          S2_W        = 72;

	localparam logic [11:0] R1_RATIO [29] = '{
		12'h008, 12'h00c, 12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060,
		12'h080, 12'h0c0, 12'h100, 12'h180, 12'h080, 12'h080, 12'h080, 12'h080,
		12'h080, 12'h080, 12'h080, 12'h080, 12'h080, 12'h080, 12'h080, 12'h080,
		12'h080, 12'h080, 12'h080, 12'h080, 12'h080};
	localparam logic [3:0] R1_LG [29] = '{
		4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9,
		4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
		4'h7, 4'h7, 4'h7, 4'h7, 4'h7};
	localparam logic [11:0] R2_RATIO [29] = '{
		12'h001, 12'h001, 12'h001, 12'h001, 12'h001, 12'h001, 12'h001, 12'h001,
		12'h001, 12'h001, 12'h001, 12'h001, 12'h004, 12'h006, 12'h008, 12'h010,
		12'h020, 12'h02d, 12'h03c, 12'h05a, 12'h0b4, 12'h12c, 12'h168, 12'h258,
		12'h2d0, 12'h384, 12'h4b0, 12'h708, 12'h960};
	localparam logic [3:0] R2_LG [29] = '{
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'ha,
		4'ha, 4'ha, 4'hb, 4'hb, 4'hc};

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_WAIT = 3'b100
	} adr_state_type;

	typedef struct packed {
		logic        settled;
		logic        short_fmt;
		logic [23:0] data;
	} adr_res_type;

endpackage

`default_nettype wire

// ### adr_sinc_stage.sv
/*
  One sinc decimation stage of runtime order 1..4 and runtime ratio.
  Assumes order is already clamped to 1..4 and ratio is at least one;
  the wide accumulators rely on two's complement wrap-around.
*/
`timescale 1ns/1ps
`default_nettype none

module adr_sinc_stage #(
	parameter int W = 60
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Control
	input  wire logic               clr,
	input  wire logic [2:0]         order,
	input  wire logic [11:0]        ratio,
	input  wire logic [3:0]         lg,
	// Sample stream
	input  wire logic               in_valid,
	input  wire logic signed [23:0] in_data,
	output logic                    out_valid,
	output logic [23:0]             out_data
);

	typedef struct packed {
		logic [3:0][W-1:0] integ;
		logic [3:0][W-1:0] dly;
		logic [11:0]       cnt;
		logic              ov;
		logic [23:0]       od;
	} adr_sinc_state_type;

	adr_sinc_state_type cur_r;
	adr_sinc_state_type cur_nxt;

	always_comb begin
		logic [W-1:0] x;
		logic [W-1:0] y;
		logic [6:0]   sh;
		cur_nxt = cur_r;
		cur_nxt.ov = 1'b0;
		x = '0;
		y = '0;
		sh = 7'({4'h0, order}) * 7'({3'h0, lg});
		if (clr) begin
			cur_nxt = '0;
		end else if (in_valid) begin
			cur_nxt.integ[0] = cur_r.integ[0] + {{(W-24){in_data[23]}}, in_data};
			for (int k = 1; k < 4; k++) begin
				cur_nxt.integ[k] = cur_r.integ[k] + cur_nxt.integ[k-1];
			end
			if (cur_r.cnt == ratio - 12'h001) begin
				cur_nxt.cnt = '0;
				x = cur_nxt.integ[2'(order - 3'h1)];
				// The comb chain runs at the decimated rate only.
				for (int k = 0; k < 4; k++) begin
					if (3'(k) < order) begin
						y = x - cur_r.dly[k];
						cur_nxt.dly[k] = x;
						x = y;
					end
				end
				// Gain is ratio^order; the shift divides by the ratio's next power of two raised to the order.
				y = W'($signed(x) >>> sh);
				cur_nxt.od = y[23:0];
				cur_nxt.ov = 1'b1;
			end else begin
				cur_nxt.cnt = cur_r.cnt + 12'h001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign out_valid = cur_r.ov;
	assign out_data  = cur_r.od;

endmodule

`default_nettype wire

// ### adr_decim.sv
/*
  Decimation filter and output-rate control: modulator clocking, a fourth
  order first stage, an optional second stage, settling control, result
  formatting, a two-entry result buffer and the APB register slave.
  Assumes the modulator changes its bit on the rising edge of mod_clk and
  that the readout path takes words with a valid/ready handshake.
*/
`timescale 1ns/1ps
`default_nettype none

module adr_decim (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// Modulator side
	output logic               mod_clk,
	input  wire logic          mod_bit_in,
	// Result stream
	output logic               res_valid,
	input  wire logic          res_ready,
	output adr_pkg::adr_res_type res_data,
	output logic               result_strobe
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0]                 ph;
		logic                        mclk;
		logic [2:0]                  sync;
		logic                        mbit;
		logic [4:0]                  rate;
		logic [2:0]                  order;
		logic                        normal;
		logic [5:0]                  waitset;
		logic                        short_sel;
		logic                        run;
		logic                        overrun;
		adr_pkg::adr_state_type      st;
		logic [2:0]                  cnt;
		logic [11:0]                 dly;
		logic [1:0][25:0]            bufm;
		logic                        wp;
		logic                        rp;
		logic [1:0]                  level;
		adr_pkg::adr_res_type        last;
		logic                        strobe;
		logic [31:0]                 rdata;
		logic                        err;
		logic                        clr_req;
	} adr_top_state_type;

	adr_top_state_type cur_r;
	adr_top_state_type cur_nxt;

	// ------------------------------------------------------------------
	// Derived configuration
	// ------------------------------------------------------------------
	logic [4:0]  code;
	logic        bypass;
	logic [2:0]  ord2;
	logic [2:0]  need;
	logic [15:0] ph_sum;
	logic        sys_tick;
	logic        mod_tick;
	logic [23:0] mod_sample;

	// Codes above the table behave as the slowest rate.
	assign code   = (cur_r.rate > adr_pkg::MAX_CODE) ? adr_pkg::MAX_CODE : cur_r.rate;
	assign bypass = (code <= adr_pkg::BYPASS_LAST);

	// An order of zero with a second-stage code still needs a filter, so it runs as order one.
	always_comb begin
		if (cur_r.order == 3'h0) begin
			ord2 = 3'h1;
		end else if (cur_r.order > adr_pkg::S2_MAX_ORD) begin
			ord2 = adr_pkg::S2_MAX_ORD;
		end else begin
			ord2 = cur_r.order;
		end
	end

	// Outputs up to and including the first settled one.
	assign need = bypass ? adr_pkg::S1_ORDER : (ord2 + 3'h1);

	// Fractional divider: one system tick per 4.608 MHz period out of pclk.
	assign ph_sum     = cur_r.ph + adr_pkg::PH_STEP;
	assign sys_tick   = (ph_sum >= adr_pkg::PH_WRAP);
	// The modulator clock toggles per system tick; its falling edge samples the bit.
	assign mod_tick   = sys_tick & cur_r.mclk;
	assign mod_sample = cur_r.mbit ? adr_pkg::MOD_POS : adr_pkg::MOD_NEG;

	// ------------------------------------------------------------------
	// Filter stages
	// ------------------------------------------------------------------
	logic        s1_v;
	logic [23:0] s1_d;
	logic        s2_v;
	logic [23:0] s2_d;
	logic        fin_v;
	logic [23:0] fin_d;

	adr_sinc_stage #(
		.W (adr_pkg::S1_W)
	) u_stage1 (
		.pclk      (pclk),
		.presetn   (presetn),
		.clr       (cur_r.clr_req),
		.order     (adr_pkg::S1_ORDER),
		.ratio     (adr_pkg::R1_RATIO[code]),
		.lg        (adr_pkg::R1_LG[code]),
		.in_valid  (mod_tick),
		.in_data   (mod_sample),
		.out_valid (s1_v),
		.out_data  (s1_d)
	);

	adr_sinc_stage #(
		.W (adr_pkg::S2_W)
	) u_stage2 (
		.pclk      (pclk),
		.presetn   (presetn),
		.clr       (cur_r.clr_req),
		.order     (ord2),
		.ratio     (adr_pkg::R2_RATIO[code]),
		.lg        (adr_pkg::R2_LG[code]),
		.in_valid  (s1_v & ~bypass),
		.in_data   (s1_d),
		.out_valid (s2_v),
		.out_data  (s2_d)
	);

	assign fin_v = bypass ? s1_v : s2_v;
	assign fin_d = bypass ? s1_d : s2_d;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic wr_acc;
	logic rd_setup;
	logic hit;

	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	always_comb begin
		case (paddr)
			adr_pkg::OFS_SETUP1,
			adr_pkg::OFS_SETUP2,
			adr_pkg::OFS_WAIT,
			adr_pkg::OFS_SYS,
			adr_pkg::OFS_STATUS,
			adr_pkg::OFS_RESULT: hit = 1'b1;
			default:             hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic                 push;
		logic                 pop;
		logic                 settled;
		logic                 ovr_set;
		logic                 cfg_wr;
		adr_pkg::adr_res_type word;
		push    = 1'b0;
		pop     = 1'b0;
		settled = 1'b0;
		ovr_set = 1'b0;
		cfg_wr  = 1'b0;
		word    = '0;
		cur_nxt = cur_r;
		cur_nxt.strobe  = 1'b0;
		cur_nxt.clr_req = 1'b0;

		// Modulator clock and three-stage input synchroniser.
		cur_nxt.ph = sys_tick ? (ph_sum - adr_pkg::PH_WRAP) : ph_sum;
		if (sys_tick) begin
			cur_nxt.mclk = ~cur_r.mclk;
		end
		cur_nxt.sync = {cur_r.sync[1:0], mod_bit_in};
		if (cur_r.sync[1] == cur_r.sync[2]) begin
			cur_nxt.mbit = cur_r.sync[2];
		end

		pop = (cur_r.level != 2'h0) & res_ready;

		case (cur_r.st)
			adr_pkg::ST_IDLE: begin
				cur_nxt.clr_req = 1'b1;
				cur_nxt.cnt     = 3'h0;
				if (cur_r.run) begin
					cur_nxt.st = adr_pkg::ST_RUN;
				end
			end
			adr_pkg::ST_RUN: begin
				if (fin_v) begin
					if (cur_r.cnt != 3'h7) begin
						cur_nxt.cnt = cur_r.cnt + 3'h1;
					end
					settled = ({1'b0, cur_r.cnt} + 4'h1) >= {1'b0, need};
					word.settled   = settled;
					word.short_fmt = cur_r.short_sel;
					// Always computed at full width; the short form keeps the top 16 bits.
					word.data = cur_r.short_sel ? {8'h00, fin_d[23:8]} : fin_d;
					// Single-cycle mode throws away the transient outputs.
					if (cur_r.normal || settled) begin
						cur_nxt.strobe = 1'b1;
						cur_nxt.last   = word;
						if (cur_r.level != 2'h2) begin
							push = 1'b1;
						end else begin
							ovr_set = 1'b1;
						end
					end
					if (!cur_r.normal && settled) begin
						cur_nxt.st  = adr_pkg::ST_WAIT;
						cur_nxt.dly = 12'(cur_r.waitset * adr_pkg::WAIT_UNIT);
					end
				end
			end
			adr_pkg::ST_WAIT: begin
				if (cur_r.dly != 12'h000) begin
					if (mod_tick) begin
						cur_nxt.dly = cur_r.dly - 12'h001;
					end
				end else if (cur_r.level != 2'h2) begin
					// A full buffer holds the next conversion back instead of losing it.
					cur_nxt.st      = adr_pkg::ST_RUN;
					cur_nxt.cnt     = 3'h0;
					cur_nxt.clr_req = 1'b1;
				end
			end
			default: begin
				cur_nxt.st = adr_pkg::ST_IDLE;
			end
		endcase

		// Register writes take effect at the access edge.
		if (wr_acc) begin
			case (paddr)
				adr_pkg::OFS_SETUP1: begin
					cur_nxt.rate  = pwdata[adr_pkg::RATE_LSB +: 5];
					cur_nxt.order = pwdata[adr_pkg::ORDER_LSB +: 3];
					cfg_wr = 1'b1;
				end
				adr_pkg::OFS_SETUP2: begin
					cur_nxt.normal = pwdata[adr_pkg::NORMAL_BIT];
					cfg_wr = 1'b1;
				end
				adr_pkg::OFS_WAIT: begin
					cur_nxt.waitset = pwdata[5:0];
				end
				adr_pkg::OFS_SYS: begin
					cur_nxt.short_sel = pwdata[adr_pkg::SHORT_BIT];
					cur_nxt.run       = pwdata[adr_pkg::RUN_BIT];
				end
				default: begin
				end
			endcase
		end

		// A new rate, order or mode restarts the filters so no mixed result escapes.
		if (cfg_wr && (cur_r.st != adr_pkg::ST_IDLE)) begin
			cur_nxt.st      = adr_pkg::ST_RUN;
			cur_nxt.cnt     = 3'h0;
			cur_nxt.clr_req = 1'b1;
		end
		if (!cur_nxt.run) begin
			cur_nxt.st = adr_pkg::ST_IDLE;
		end

		// Overrun is write-one-to-clear; a new overrun in the same cycle wins.
		cur_nxt.overrun = ovr_set | (cur_r.overrun &
			~(wr_acc && (paddr == adr_pkg::OFS_STATUS) && pwdata[adr_pkg::OVR_BIT]));

		// Two-entry result buffer.
		if (push) begin
			cur_nxt.bufm[cur_r.wp] = word;
			cur_nxt.wp = ~cur_r.wp;
		end
		if (pop) begin
			cur_nxt.rp = ~cur_r.rp;
		end
		cur_nxt.level = cur_r.level + {1'b0, push} - {1'b0, pop};

		// Read data is captured in the setup cycle and shown in the access cycle.
		if (rd_setup) begin
			cur_nxt.err   = ~hit | (paddr[1:0] != 2'h0);
			cur_nxt.rdata = 32'h00000000;
			case (paddr)
				adr_pkg::OFS_SETUP1: begin
					cur_nxt.rdata[adr_pkg::RATE_LSB +: 5]  = cur_r.rate;
					cur_nxt.rdata[adr_pkg::ORDER_LSB +: 3] = cur_r.order;
				end
				adr_pkg::OFS_SETUP2: begin
					cur_nxt.rdata[adr_pkg::NORMAL_BIT] = cur_r.normal;
				end
				adr_pkg::OFS_WAIT: begin
					cur_nxt.rdata[5:0] = cur_r.waitset;
				end
				adr_pkg::OFS_SYS: begin
					cur_nxt.rdata[adr_pkg::SHORT_BIT] = cur_r.short_sel;
					cur_nxt.rdata[adr_pkg::RUN_BIT]   = cur_r.run;
				end
				adr_pkg::OFS_STATUS: begin
					cur_nxt.rdata[adr_pkg::OVR_BIT]       = cur_r.overrun;
					cur_nxt.rdata[adr_pkg::SETTLED_BIT]   = cur_r.last.settled;
					cur_nxt.rdata[adr_pkg::LEVEL_LSB +: 2] = cur_r.level;
					cur_nxt.rdata[adr_pkg::STATE_LSB +: 3] = cur_r.st;
				end
				adr_pkg::OFS_RESULT: begin
					cur_nxt.rdata[23:0]                 = cur_r.last.data;
					cur_nxt.rdata[adr_pkg::RES_SET_BIT] = cur_r.last.settled;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_r           <= '0;
			cur_r.rate      <= adr_pkg::RATE_RST;
			cur_r.order     <= adr_pkg::ORDER_RST;
			cur_r.normal    <= adr_pkg::NORMAL_RST;
			cur_r.waitset   <= adr_pkg::WAIT_RST;
			cur_r.short_sel <= adr_pkg::SHORT_RST;
			cur_r.run       <= adr_pkg::RUN_RST;
			cur_r.st        <= adr_pkg::ST_IDLE;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign pready        = 1'b1;
	assign prdata        = cur_r.rdata;
	assign pslverr       = cur_r.err;
	assign mod_clk       = cur_r.mclk;
	assign res_valid     = (cur_r.level != 2'h0);
	assign res_data      = adr_pkg::adr_res_type'(cur_r.bufm[cur_r.rp]);
	assign result_strobe = cur_r.strobe;

endmodule

`default_nettype wire

// ### adr_mod_model.sv
/*
  Behavioural modulator at the far side of the decimation block.
  Assumes the block samples the bit on the falling modulator clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module adr_mod_model (
	// Modulator pins
	input  wire logic mod_clk,
	output logic      mod_bit,
	// Stimulus
	input  wire logic level
);
	// The bit moves only on the rising edge, so it is steady when sampled.
	always @(posedge mod_clk) begin
		mod_bit <= level;
	end
endmodule

`default_nettype wire

// ### adr_decim_checker.sv
/*
  Port checker of the decimation block: bus answers, modulator clock,
  result strobe and result buffer. Assumes one clock and an async reset.
*/
`timescale 1ns/1ps
`default_nettype none

module adr_decim_checker (
	// Clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// APB
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Modulator and results
	input wire logic                 mod_clk,
	input wire logic                 mod_bit_in,
	input wire logic                 res_valid,
	input wire logic                 res_ready,
	input wire adr_pkg::adr_res_type res_data,
	input wire logic                 result_strobe
);
	// Eight samples at the shortest spacing of 17 cycles are 136 cycles.
	logic [15:0] gap_r;
	logic        seen_r;
	logic        bad;
	assign bad = (paddr[1:0] != 2'h0) || (paddr > 8'h14);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= 16'h0000;
			seen_r <= 1'b0;
		end else if (result_strobe) begin
			gap_r <= 16'h0001;
			seen_r <= 1'b1;
		end else if (gap_r != 16'hffff) begin
			gap_r <= gap_r + 16'h0001;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_mod_hold;
		$stable(mod_clk)[*7] ##[1:2] $changed(mod_clk);
	endsequence
	property p_mod_rate;
		$changed(mod_clk) |=> s_mod_hold;
	endproperty
	a_mod_rate: assert property (p_mod_rate)
		else $error("modulator clock half period out of range");
	property p_gap;
		result_strobe && seen_r |-> gap_r >= 16'h0088;
	endproperty
	a_gap: assert property (p_gap)
		else $error("results closer than the fastest rate");
	property p_pulse;
		result_strobe |=> !result_strobe;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("result strobe longer than one cycle");
	property p_push;
		result_strobe |-> res_valid;
	endproperty
	a_push: assert property (p_push)
		else $error("strobe without a buffered word");
	property p_hold;
		res_valid && !res_ready |=> res_valid && $stable(res_data);
	endproperty
	a_hold: assert property (p_hold)
		else $error("stalled word changed or vanished");
	property p_short;
		res_valid && res_data.short_fmt |-> res_data.data[23:16] == 8'h00;
	endproperty
	a_short: assert property (p_short)
		else $error("short result has upper bits set");
	property p_err;
		psel && !penable |=> pslverr == $past(bad);
	endproperty
	a_err: assert property (p_err)
		else $error("slave error does not match the address");
	property p_bad_data;
		psel && !penable && bad |=> prdata == 32'h00000000;
	endproperty
	a_bad_data: assert property (p_bad_data)
		else $error("refused address returned data");
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("access phase not answered");
endmodule

`default_nettype wire

// ### adr_decim_test.sv
/*
  Self-checking bench of the decimation block with a modulator model.
  Assumes a 40 MHz clock and that the modulator clock runs freely.
*/
`timescale 1ns/1ps
`default_nettype none

module adr_decim_test;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 mod_clk;
	logic                 mod_bit_in;
	logic                 res_valid;
	logic                 res_ready;
	adr_pkg::adr_res_type res_data;
	logic                 result_strobe;
	logic                 lvl;
	logic                 mclk_q;
	int                   n_smp = 0;
	int                   n_errors;
	int                   check_count;

	adr_decim dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mod_clk(mod_clk), .mod_bit_in(mod_bit_in),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
		.result_strobe(result_strobe));
	adr_mod_model u_mod (.mod_clk(mod_clk), .mod_bit(mod_bit_in), .level(lvl));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// Modulator samples are counted, so rates do not depend on clock jitter.
	always @(posedge pclk) begin
		mclk_q <= mod_clk;
		if (mclk_q && !mod_clk) n_smp <= n_smp + 1;
	end

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic logic [31:0] inr(input int d, input int lo);
		return {31'h0, d >= lo && d <= lo + 2};
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk("read data", r, exp);
		chk("slave error", {31'h0, e}, {31'h0, err});
	endtask
	task automatic cfg(input logic [4:0] code, input logic [2:0] ord, input logic nrm,
		input logic [5:0] wt, input logic sh);
		wr(8'h0c, {31'h0, sh});
		wr(8'h08, {26'h0, wt});
		wr(8'h00, {21'h0, ord, 3'h0, code});
		wr(8'h04, {31'h0, nrm});
		wr(8'h0c, {30'h0, 1'b1, sh});
	endtask
	task automatic wait_res(output adr_pkg::adr_res_type w, output int s);
		do @(posedge pclk); while (result_strobe !== 1'b1);
		w = res_data;
		s = n_smp;
	endtask
	task automatic span(output int d);
		adr_pkg::adr_res_type w;
		int s0;
		int s1;
		wait_res(w, s0);
		wait_res(w, s1);
		d = s1 - s0;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_regs();
		rd(8'h00, 32'h0, 1'b0);
		rd(8'h04, 32'h1, 1'b0);
		rd(8'h08, 32'h0, 1'b0);
		rd(8'h0c, 32'h0, 1'b0);
		rd(8'h10, 32'h10, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
		wr(8'h00, 32'hffffffff);
		rd(8'h00, 32'h71f, 1'b0);
		wr(8'h08, 32'hffffffff);
		rd(8'h08, 32'h3f, 1'b0);
	endtask
	task automatic t_rates();
		logic [4:0] code [4] = '{5'h00, 5'h01, 5'h05, 5'h09};
		int oversampling_ratio [4] = '{8, 12, 48, 192};
		int d;
		for (int i = 0; i < 4; i++) begin
			cfg(code[i], 3'h0, 1'b1, 6'h00, 1'b0);
			span(d);
			chk("normal interval", d, oversampling_ratio[i]);
		end
		cfg(5'h0c, 3'h1, 1'b1, 6'h00, 1'b0);
		span(d);
		chk("normal interval", d, 512);
		cfg(5'h0c, 3'h1, 1'b0, 6'h00, 1'b0);
		span(d);
		chk("single interval", inr(d, 1024), 32'h1);
	endtask
	// Single-cycle settling is what a scanning controller would pick.
	task automatic t_single();
		adr_pkg::adr_res_type w;
		int s;
		int d;
		cfg(5'h00, 3'h0, 1'b0, 6'h00, 1'b0);
		span(d);
		chk("single interval", inr(d, 32), 32'h1);
		wait_res(w, s);
		chk("single result", w, {2'b10, 24'h400000});
		lvl <= 1'b0;
		wait_res(w, s);
		chk("single step", w, {2'b10, 24'hc00000});
		lvl <= 1'b1;
		cfg(5'h00, 3'h0, 1'b0, 6'h01, 1'b0);
		span(d);
		chk("delayed interval", inr(d, 96), 32'h1);
	endtask
	task automatic t_step();
		adr_pkg::adr_res_type w;
		adr_pkg::adr_res_type r [5];
		int s;
		lvl <= 1'b0;
		cfg(5'h00, 3'h0, 1'b1, 6'h00, 1'b0);
		for (int i = 0; i < 6; i++) wait_res(w, s);
		chk("settled low", w, {2'b10, 24'hc00000});
		lvl <= 1'b1;
		for (int i = 0; i < 5; i++) wait_res(r[i], s);
		chk("first after step", {31'h0, r[0].data == 24'h400000}, 32'h0);
		chk("settled after step", r[4], {2'b10, 24'h400000});
	endtask
	task automatic t_short();
		adr_pkg::adr_res_type w;
		int s;
		cfg(5'h00, 3'h0, 1'b1, 6'h00, 1'b1);
		for (int i = 0; i < 6; i++) wait_res(w, s);
		chk("short result", w, {2'b11, 24'h004000});
	endtask
	task automatic t_buffer();
		adr_pkg::adr_res_type w;
		int s;
		res_ready <= 1'b0;
		cfg(5'h00, 3'h0, 1'b1, 6'h00, 1'b0);
		for (int i = 0; i < 3; i++) wait_res(w, s);
		rd(8'h10, 32'h29, 1'b0);
		res_ready <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("drained", {31'h0, res_valid}, 32'h0);
		wr(8'h10, 32'h1);
		rd(8'h10, 32'h20, 1'b0);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		res_ready = 1'b1;
		lvl = 1'b1;
		n_errors = 0;
		check_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rates();
		t_single();
		t_step();
		t_short();
		t_buffer();
		test_done();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		test_done();
	end
endmodule

bind adr_decim adr_decim_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .mod_clk(mod_clk), .mod_bit_in(mod_bit_in),
	.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
	.result_strobe(result_strobe));

`default_nettype wire
